// [design/ghss_core.sv]
// Handshake status register and serial poll response register
//
// Behaviour
// - New-byte-available is high when direction is not input and FIFO holds data.
// - End holdoff sets on EOI byte, enabled end-string match, or enabled newline.
// - End holdoff clears only on the release-holdoff command.
// - Not-ready holdoff sets on the same end conditions.
// - Not-ready holdoff also sets on any accepted byte outside continuous mode.
// - Not-ready holdoff clears on holdoff false, release-holdoff or continuous-listen.
// - Immediate holdoff sets on hold-immediately command, clears on release-holdoff.
// - Data-accept holdoff set while active, cleared by valid or invalid command.
// - Acceptor idle when attention set and listener not addressed.
// - Non-idle without DAV: ready bit clear is not-ready, set is ready.
// - Data-accept state: non-idle, DAV, ready; or not ready with attention and holdoff.
// - Wait-for-new-cycle: non-idle, not ready, DAV, qualified by attention and holdoff.
// - Source idle unless talker addressed and attention status both set.
// - Non-idle source state encoded in two bits: generate, delay, transfer.
// - Handshake status register is eight bits, read-only, offset 0x1B, reset 0x00.
// - Serial poll drives the response register onto the data lines, with bit 6 taken from RQS or service pending.
// - Status byte bits form the response; register is write-only, reset 0x00.
// - In mode two the request-service bit is returned as RQS.
// - In mode three setting the request-service bit asserts SRQ.
// - Service pending asserts on request in modes two and three, clears when serial polled.
`timescale 1ns/10ps
`include "ghss_map.svh"
module ghss_core (
  input  wire logic                  sys_clk_i,
  input  wire logic                  arst_n_i,
  input  wire ghss_pkg::ghss_bus_type bus_i,
  input  wire ghss_pkg::ghss_evt_type evt_i,
  input  wire logic                  listener_active_i,
  input  wire logic                  attention_line_status_i,
  input  wire logic                  speaker_selected_i,
  input  wire logic                  dav_i,
  input  wire logic                  spoll_active_i,
  output logic [7:0]                 rdata_o,
  output logic [7:0]                 dio_o,
  output logic                       dio_oe_n_o,
  output logic                       srq_o,
  output logic                       rqs_o,
  output logic                       service_pending_o,
  output logic [4:0]                 acceptor_state_o,
  output logic [3:0]                 source_state_o
);
  import ghss_pkg::*;

  ghss_state_type  st_q;
  ghss_state_type  st_d;
  logic [7:0]      status;
  logic            end_cond;
  logic            cmd_wr;
  ghss_spmode_type mode;
  logic            aids;
  logic            sids;
  logic            rsv;

  // Mode from two config bits; an unused code falls back to mode one
  always_comb
  begin
    case (st_q.cfg[`GHSS_CFG_MODE_LSB +: 2])
      2'h1:    mode = GHSS_SP_TWO;
      2'h2:    mode = GHSS_SP_THREE;
      default: mode = GHSS_SP_ONE;
    endcase
  end

  assign cmd_wr = bus_i.wr && (bus_i.addr == `GHSS_AUX_CMD_OFS);
  assign rsv    = st_q.spoll_resp[`GHSS_SRQ_BIT];
  assign end_cond = evt_i.byte_stb && (evt_i.eoi ||
    (st_q.cfg[`GHSS_CFG_EOS_EN_BIT] && evt_i.byte_val == st_q.eos) ||
    (st_q.cfg[`GHSS_CFG_NL_EN_BIT] && evt_i.byte_val == `GHSS_NL_CHAR));

  always_comb
  begin
    status = `GHSS_HS_STATUS_RST;
    status[`GHSS_NBA_BIT]   = !st_q.cfg[`GHSS_CFG_DIR_IN_BIT] && !evt_i.fifo_empty;
    status[`GHSS_END_HOLDOFF_STATE_BIT]  = st_q.end_hold;
    status[`GHSS_ANH1_BIT]  = st_q.nrdy_hold;
    status[`GHSS_ANH2_BIT]  = st_q.imm_hold;
    status[`GHSS_DATA_ACCEPT_HOLDOFF_STATE_BIT]  = st_q.dac_hold;
    status[`GHSS_ACCEPTOR_READY_FLAG_BIT] = evt_i.acc_ready;
    status[`GHSS_SHA_BIT]   = evt_i.src_a;
    status[`GHSS_SHB_BIT]   = evt_i.src_b;
  end

  always_comb
  begin
    st_d = st_q;
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        `GHSS_SPOLL_RESP_OFS: st_d.spoll_resp = bus_i.wdata;
        `GHSS_CFG_OFS:        st_d.cfg = bus_i.wdata;
        `GHSS_EOS_OFS:        st_d.eos = bus_i.wdata;
        default:              st_d.cfg = st_q.cfg;
      endcase
    end
    // Holdoff clears first so a same-cycle set wins; service pending yields to poll done
    if (cmd_wr && bus_i.wdata == `GHSS_CMD_RELEASE_HOLDOFF)
    begin
      st_d.end_hold = 1'b0;
      st_d.imm_hold = 1'b0;
    end
    if (evt_i.holdoff_false || (cmd_wr && (bus_i.wdata == `GHSS_CMD_RELEASE_HOLDOFF ||
        bus_i.wdata == `GHSS_CMD_LISTEN_CONTINUOUS_CMD)))
      st_d.nrdy_hold = 1'b0;
    if (cmd_wr && (bus_i.wdata == `GHSS_CMD_VALID || bus_i.wdata == `GHSS_CMD_INVALID))
      st_d.dac_hold = 1'b0;
    if (end_cond)
    begin
      st_d.end_hold  = 1'b1;
      st_d.nrdy_hold = 1'b1;
    end
    if (evt_i.byte_stb && !st_q.cfg[`GHSS_CFG_CONT_BIT])
      st_d.nrdy_hold = 1'b1;
    if (cmd_wr && bus_i.wdata == `GHSS_CMD_HOLD_IMMEDIATELY)
      st_d.imm_hold = 1'b1;
    if (evt_i.dac_holdoff)
      st_d.dac_hold = 1'b1;
    if (evt_i.spoll_done)
      st_d.service_pending = 1'b0;
    if (mode != GHSS_SP_ONE && rsv && !evt_i.spoll_done)
      st_d.service_pending = 1'b1;
    // Read has no side effect; the response register reads as zero
    st_d.rdata = (bus_i.rd && bus_i.addr == `GHSS_HS_STATUS_OFS) ? status : 8'h00;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q <= '0;
      st_q.spoll_resp <= `GHSS_SPOLL_RST;
      st_q.cfg        <= `GHSS_CFG_RST;
      st_q.eos        <= `GHSS_EOS_RST;
    end
    else
      st_q <= st_d;
  end

  // Mode one never answers with RQS; software keeps the bit clear there
  assign rqs_o = (mode == GHSS_SP_TWO) && rsv;
  assign srq_o = ((mode == GHSS_SP_THREE) && rsv) || st_q.service_pending;
  assign dio_o = {st_q.spoll_resp[7], rqs_o || st_q.service_pending, st_q.spoll_resp[5:0]};
  assign dio_oe_n_o = !spoll_active_i;
  assign service_pending_o = st_q.service_pending;
  assign rdata_o = st_q.rdata;

  assign aids = attention_line_status_i && !listener_active_i;
  assign acceptor_state_o[0] = aids;
  assign acceptor_state_o[1] = !aids && !evt_i.acc_ready && !dav_i;
  assign acceptor_state_o[2] = !aids && evt_i.acc_ready && !dav_i;
  assign acceptor_state_o[3] = !aids && dav_i && (evt_i.acc_ready ||
    (attention_line_status_i && st_q.dac_hold));
  assign acceptor_state_o[4] = !aids && !evt_i.acc_ready && dav_i &&
    attention_line_status_i && st_q.dac_hold;
  assign sids = !(speaker_selected_i && attention_line_status_i);
  assign source_state_o[0] = sids;
  assign source_state_o[1] = !sids && !evt_i.src_a && !evt_i.src_b;
  assign source_state_o[2] = !sids && evt_i.src_a;
  assign source_state_o[3] = !sids && !evt_i.src_a && evt_i.src_b;

  // Bus events shared by the properties below
  sequence release_holdoff_cmd_s;
    cmd_wr && bus_i.wdata == `GHSS_CMD_RELEASE_HOLDOFF;
  endsequence

  sequence hold_immediately_cmd_s;
    cmd_wr && bus_i.wdata == `GHSS_CMD_HOLD_IMMEDIATELY;
  endsequence

  sequence listen_cont_s;
    cmd_wr && bus_i.wdata == `GHSS_CMD_LISTEN_CONTINUOUS_CMD;
  endsequence

  sequence dac_clear_s;
    cmd_wr && (bus_i.wdata == `GHSS_CMD_VALID || bus_i.wdata == `GHSS_CMD_INVALID);
  endsequence

  sequence status_read_s;
    bus_i.rd && bus_i.addr == `GHSS_HS_STATUS_OFS;
  endsequence

  sequence spoll_write_s;
    bus_i.wr && bus_i.addr == `GHSS_SPOLL_RESP_OFS;
  endsequence

  end_hold_set_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    end_cond |=> st_q.end_hold) else $error("end holdoff not set");

  end_hold_keep_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    st_q.end_hold && !(cmd_wr && bus_i.wdata == `GHSS_CMD_RELEASE_HOLDOFF) |=> st_q.end_hold)
    else $error("end holdoff lost");

  end_hold_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    release_holdoff_cmd_s ##0 (!end_cond)
    |=> !st_q.end_hold)
    else $error("end holdoff not released");

  nrdy_set_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    evt_i.byte_stb && !st_q.cfg[`GHSS_CFG_CONT_BIT] |=> st_q.nrdy_hold)
    else $error("not ready holdoff not set");

  nrdy_end_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    end_cond
    |=> st_q.nrdy_hold)
    else $error("not ready holdoff missed end");

  nrdy_false_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    evt_i.holdoff_false && !evt_i.byte_stb
    |=> !st_q.nrdy_hold)
    else $error("not ready holdoff kept after holdoff false");

  nrdy_release_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    release_holdoff_cmd_s ##0 (!evt_i.byte_stb)
    |=> !st_q.nrdy_hold)
    else $error("not ready holdoff kept after release");

  nrdy_listen_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    listen_cont_s ##0 (!evt_i.byte_stb)
    |=> !st_q.nrdy_hold)
    else $error("not ready holdoff kept after continuous listen");

  imm_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    hold_immediately_cmd_s |=> st_q.imm_hold)
    else $error("immediate holdoff not set");

  imm_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    release_holdoff_cmd_s
    |=> !st_q.imm_hold)
    else $error("immediate holdoff not released");

  imm_keep_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    st_q.imm_hold && !(cmd_wr && bus_i.wdata == `GHSS_CMD_RELEASE_HOLDOFF)
    |=> st_q.imm_hold)
    else $error("immediate holdoff lost");

  dac_set_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    evt_i.dac_holdoff
    |=> st_q.dac_hold)
    else $error("data accept holdoff not set");

  dac_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    dac_clear_s ##0 (!evt_i.dac_holdoff)
    |=> !st_q.dac_hold)
    else $error("data accept holdoff not released");

  dac_keep_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    st_q.dac_hold && !(cmd_wr && (bus_i.wdata == `GHSS_CMD_VALID || bus_i.wdata == `GHSS_CMD_INVALID))
    |=> st_q.dac_hold)
    else $error("data accept holdoff lost");

  acc_idle_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    attention_line_status_i && !listener_active_i
    |-> acceptor_state_o == 5'h01)
    else $error("acceptor not idle");

  acc_ready_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !aids && !dav_i
    |-> acceptor_state_o == (evt_i.acc_ready ? 5'h04 : 5'h02))
    else $error("acceptor ready state wrong");

  acc_accept_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !aids && dav_i && evt_i.acc_ready
    |-> acceptor_state_o == 5'h08)
    else $error("acceptor accept state wrong");

  acc_wait_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !aids && dav_i && !evt_i.acc_ready
    |-> acceptor_state_o == ((attention_line_status_i && st_q.dac_hold) ? 5'h18 : 5'h00))
    else $error("acceptor wait state wrong");

  src_idle_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !(speaker_selected_i && attention_line_status_i)
    |-> source_state_o == 4'h1)
    else $error("source not idle");

  src_onehot_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    speaker_selected_i && attention_line_status_i
    |-> $onehot(source_state_o) && !source_state_o[0] && source_state_o[2] == evt_i.src_a)
    else $error("source state encoding wrong");

  read_data_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    bus_i.rd && bus_i.addr == `GHSS_HS_STATUS_OFS |=> rdata_o == $past(status))
    else $error("status read wrong");

  nba_read_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    status_read_s ##0 (!st_q.cfg[`GHSS_CFG_DIR_IN_BIT] && !evt_i.fifo_empty)
    |=> rdata_o[`GHSS_NBA_BIT])
    else $error("new byte flag not read");

  live_ready_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    status_read_s
    |=> rdata_o[`GHSS_ACCEPTOR_READY_FLAG_BIT] == $past(evt_i.acc_ready))
    else $error("ready bit not live");

  other_read_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    bus_i.rd && bus_i.addr != `GHSS_HS_STATUS_OFS
    |=> rdata_o == 8'h00)
    else $error("other read not zero");

  idle_read_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !bus_i.rd
    |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");

  spoll_drive_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    spoll_active_i |-> !dio_oe_n_o && dio_o[5:0] == st_q.spoll_resp[5:0])
    else $error("serial poll byte not driven");

  poll_release_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !spoll_active_i
    |-> dio_oe_n_o)
    else $error("data lines driven outside poll");

  resp_write_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    spoll_write_s
    |=> st_q.spoll_resp == $past(bus_i.wdata))
    else $error("response write lost");

  srq_mode3_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    mode == GHSS_SP_THREE && rsv |-> srq_o) else $error("SRQ not asserted");

  srq_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    mode != GHSS_SP_THREE && !st_q.service_pending
    |-> !srq_o)
    else $error("service request without cause");

  rqs_mode2_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    mode == GHSS_SP_TWO
    |-> rqs_o == rsv)
    else $error("RQS not the request bit");

  service_pending_set_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    mode != GHSS_SP_ONE && rsv && !evt_i.spoll_done
    |=> service_pending_o)
    else $error("pending not set");

  service_pending_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    service_pending_o && !evt_i.spoll_done
    |=> service_pending_o)
    else $error("pending lost before poll");

  service_pending_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    evt_i.spoll_done |=> !service_pending_o) else $error("pending not cleared");
endmodule

// [design/ghss_map.svh]
// Register offsets, field positions, reset values and command codes
`ifndef GHSS_MAP_SVH
`define GHSS_MAP_SVH
`define GHSS_SPOLL_RESP_OFS   8'h06
`define GHSS_HS_STATUS_OFS    8'h1B
`define GHSS_AUX_CMD_OFS      8'h05
`define GHSS_CFG_OFS          8'h20
`define GHSS_SPOLL_RST        8'h00
`define GHSS_HS_STATUS_RST    8'h00
`define GHSS_CFG_RST          8'h00
`define GHSS_EOS_RST          8'h00
`define GHSS_NL_CHAR          8'h0A
`define GHSS_SRQ_BIT          6
`define GHSS_NBA_BIT          7
`define GHSS_END_HOLDOFF_STATE_BIT         6
`define GHSS_ANH1_BIT         5
`define GHSS_ANH2_BIT         4
`define GHSS_DATA_ACCEPT_HOLDOFF_STATE_BIT         3
`define GHSS_ACCEPTOR_READY_FLAG_BIT        2
`define GHSS_SHA_BIT          1
`define GHSS_SHB_BIT          0
`define GHSS_CFG_DIR_IN_BIT   0
`define GHSS_CFG_EOS_EN_BIT   1
`define GHSS_CFG_NL_EN_BIT    2
`define GHSS_CFG_CONT_BIT     3
`define GHSS_CFG_MODE_LSB     4
`define GHSS_CMD_RELEASE_HOLDOFF         8'h03
`define GHSS_CMD_HOLD_IMMEDIATELY         8'h51
`define GHSS_CMD_LISTEN_CONTINUOUS_CMD     8'h13
`define GHSS_CMD_VALID        8'h0F
`define GHSS_CMD_INVALID      8'h07
`define GHSS_EOS_OFS          8'h21
`endif

// [design/ghss_pkg.sv]
// Types for the handshake status and serial poll block
package ghss_pkg;
  typedef enum logic [2:0] {
    GHSS_SP_ONE   = 3'b001,
    GHSS_SP_TWO   = 3'b010,
    GHSS_SP_THREE = 3'b100
  } ghss_spmode_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ghss_bus_type;

  typedef struct packed {
    logic       byte_stb;
    logic [7:0] byte_val;
    logic       eoi;
    logic       dac_holdoff;
    logic       holdoff_false;
    logic       fifo_empty;
    logic       acc_ready;
    logic       src_a;
    logic       src_b;
    logic       spoll_done;
  } ghss_evt_type;

  typedef struct packed {
    logic [7:0] spoll_resp;
    logic [7:0] cfg;
    logic [7:0] eos;
    logic       end_hold;
    logic       nrdy_hold;
    logic       imm_hold;
    logic       dac_hold;
    logic       service_pending;
    logic [7:0] rdata;
  } ghss_state_type;
endpackage

// [test/ghss_ctrl_model.sv]
// Controller model that serial polls the block and captures its response byte
`timescale 1ns/10ps
module ghss_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] dio_i,
  input  wire logic       oe_n_i,
  output logic            active_o,
  output logic            done_o,
  output logic [8:0]      byte_o
);
  int n = 0;
  // Capture late in the poll so the response has settled on the lines
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (go_i) n <= 3;
    if (n > 0) n <= n - 1;
    active_o <= (n > 1) || go_i;
    if (n == 1)
    begin
      byte_o <= {oe_n_i, dio_i};
      done_o <= 1'b1;
    end
  end
endmodule

// [test/gpib_handshake_status_spoll_bench.sv]
// Self-checking bench for the handshake status and serial poll block
`timescale 1ns/10ps
`include "ghss_map.svh"
module gpib_handshake_status_spoll_bench;
  import ghss_pkg::*;
  logic         clk = 0, rst_n = 0, go = 0, la = 0, atn = 0, spk = 0, dav = 0, rd_p = 0, act, done, oe_n, y, z, d;
  ghss_bus_type bus = '0;
  ghss_evt_type evt = '{fifo_empty: 1'b1, default: '0};
  ghss_evt_type evt_w;
  logic [7:0]   rdata, dio, eos, v, q[$];
  logic         srq, rqs, service_pending;
  logic [4:0]   acc;
  logic [3:0]   src;
  logic [8:0]   pb, pq[$];
  logic [31:0]  r;
  int           errors = 0, n_tests = 0, cyc = 0;
  ghss_core dut (.sys_clk_i(clk), .arst_n_i(rst_n), .bus_i(bus), .evt_i(evt_w), .listener_active_i(la),
    .attention_line_status_i(atn), .speaker_selected_i(spk), .dav_i(dav), .spoll_active_i(act), .rdata_o(rdata),
    .dio_o(dio), .dio_oe_n_o(oe_n), .srq_o(srq), .rqs_o(rqs), .service_pending_o(service_pending), .acceptor_state_o(acc),
    .source_state_o(src));
  ghss_ctrl_model ctl (.clk_i(clk), .go_i(go), .dio_i(dio), .oe_n_i(oe_n), .active_o(act), .done_o(done),
    .byte_o(pb));
  // The poll-done pulse comes from the controller model, all else from the stimulus
  always_comb
  begin
    evt_w = evt;
    evt_w.spoll_done = done;
  end
  initial forever #12.5 clk = ~clk;
  task chk(input string s, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    rd_p <= bus.rd;
    if (cyc == 5000)
    begin
      errors++;
      print_verdict;
    end
  end
  // Read data stand only in the cycle after the strobe, so look mid-cycle
  always @(negedge clk)
  begin
    if (rd_p) chk("rdata", 9'(q.pop_front()), 9'(rdata));
    if (done) chk("poll byte", pq.pop_front(), pb);
  end
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] dt);
    @(posedge clk);
    bus <= '{wr: w, rd: !w, addr: a, wdata: dt};
    @(posedge clk);
    bus <= '0;
  endtask
  task bw(input logic [7:0] a, input logic [7:0] dt);
    xfer(1'b1, a, dt);
  endtask
  task br(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask
  task ev(input logic b, input logic [7:0] bv, input logic e, input logic dh, input logic hf);
    @(posedge clk);
    {evt.byte_stb, evt.byte_val, evt.eoi, evt.dac_holdoff, evt.holdoff_false} <= {b, bv, e, dh, hf};
    @(posedge clk);
    {evt.byte_stb, evt.eoi, evt.dac_holdoff, evt.holdoff_false} <= 4'h0;
  endtask
  task hs(input logic [3:0] e);
    br(`GHSS_HS_STATUS_OFS, {1'b0, e, 3'h0});
  endtask
  task ax(input logic [7:0] c, input logic [3:0] e);
    bw(`GHSS_AUX_CMD_OFS, c);
    hs(e);
  endtask
  task bt(input logic [7:0] c, input logic [7:0] bv, input logic e, input logic [3:0] x);
    bw(`GHSS_CFG_OFS, c);
    ev(1'b1, bv, e, 1'b0, 1'b0);
    hs(x);
  endtask
  initial
  begin
    void'($urandom(45047));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    eos = 8'($urandom);
    br(`GHSS_HS_STATUS_OFS, 8'h00);
    br(`GHSS_SPOLL_RESP_OFS, 8'h00);
    br(8'h40, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      r = $urandom;
      bw(`GHSS_CFG_OFS, {7'h0, r[4]});
      {evt.fifo_empty, evt.acc_ready, evt.src_a, evt.src_b} <= r[3:0];
      repeat (2) br(`GHSS_HS_STATUS_OFS, {~r[4] & ~r[3], 4'h0, r[2:0]});
    end
    {evt.fifo_empty, evt.acc_ready, evt.src_a, evt.src_b} <= 4'h8;
    $display("test live status done");
    bw(`GHSS_EOS_OFS, eos);
    bt(8'h08, `GHSS_NL_CHAR, 1'b0, 4'h0);
    bt(8'h08, 8'h41, 1'b1, 4'hC);
    ev(1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    hs(4'h8);
    ax(`GHSS_CMD_LISTEN_CONTINUOUS_CMD, 4'h8);
    ax(`GHSS_CMD_RELEASE_HOLDOFF, 4'h0);
    bt(8'h0C, `GHSS_NL_CHAR, 1'b0, 4'hC);
    ax(`GHSS_CMD_RELEASE_HOLDOFF, 4'h0);
    bt(8'h0A, eos, 1'b0, 4'hC);
    ax(`GHSS_CMD_RELEASE_HOLDOFF, 4'h0);
    bt(8'h00, 8'h41, 1'b0, 4'h4);
    ax(`GHSS_CMD_LISTEN_CONTINUOUS_CMD, 4'h0);
    ax(`GHSS_CMD_HOLD_IMMEDIATELY, 4'h2);
    ax(`GHSS_CMD_RELEASE_HOLDOFF, 4'h0);
    ev(1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
    ax(`GHSS_CMD_VALID, 4'h0);
    ev(1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
    hs(4'h1);
    ax(`GHSS_CMD_INVALID, 4'h0);
    $display("test holdoffs done");
    for (int m = 0; m < 4; m++)
    begin
      v = 8'($urandom);
      v[6] = (m == 1 || m == 2);
      bw(`GHSS_CFG_OFS, {2'h0, 2'(m), 4'h0});
      bw(`GHSS_SPOLL_RESP_OFS, v);
      repeat (2) @(posedge clk);
      #1 chk("rqs", 9'(m == 1), 9'(rqs));
      chk("srq", 9'(v[6]), 9'(srq));
      chk("pending", 9'(v[6]), 9'(service_pending));
      bw(`GHSS_SPOLL_RESP_OFS, v & 8'hBF);
      pq.push_back({1'b0, v});
      @(posedge clk) go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk("pending", 9'h000, 9'(service_pending));
      chk("release", 9'h001, 9'(oe_n));
    end
    $display("test serial poll done");
    for (int i = 0; i < 32; i++)
    begin
      if (i == 16) ev(1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
      r = $urandom;
      @(posedge clk);
      {atn, la, dav, evt.acc_ready, spk, evt.src_a, evt.src_b} <= {i[3:0], r[2:0]};
      #1 y = i[3] & ~i[2];
      z = ~(r[2] & i[3]);
      d = i >= 16;
      chk("acceptor", {4'h0, ~y & ~i[0] & i[1] & i[3] & d, ~y & i[1] & (i[0] | i[3] & d), ~y & i[0] & ~i[1],
        ~y & ~i[0] & ~i[1], y}, 9'(acc));
      chk("source", {5'h0, ~z & ~r[1] & r[0], ~z & r[1], ~z & ~r[1] & ~r[0], z}, 9'(src));
    end
    $display("test handshake states done");
    print_verdict;
  end
endmodule
